// >>> design/cfig_pkg.sv
`default_nettype none
package cfig_pkg;
    // Flag register layout (one aligned word at its own offset)
    localparam logic [7:0] FLAG_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] IRQ_OFS       = 8'h08;
    localparam int         BANK_BIT      = 0;
    localparam int         OVF_BIT       = 1;
    localparam int         IEN_BIT       = 2;
    localparam int         SSEL_BIT      = 3;
    localparam int         LVL_LSB       = 4;
    localparam int         LVL_W         = 3;
    localparam logic [7:0] FLAG_RST      = 8'h00;
    localparam logic [7:0] FLAG_WMASK    = 8'h7f;
    localparam logic [5:0] TRAP_MAX      = 6'h1f;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : cfig_pkg
`default_nettype wire

// >>> design/cfig_accept.sv
`default_nettype none
module cfig_accept (
    input  wire logic       irq_req_in,
    input  wire logic       irq_nmi_in,
    input  wire logic [2:0] irq_level_in,
    input  wire logic       ien_in,
    input  wire logic [2:0] core_priority_level_in,
    output logic            take_out
);
    always_comb
    begin
        // Non-maskable bypasses the gate
        take_out = irq_req_in && (irq_nmi_in ||
                   (ien_in && (irq_level_in > core_priority_level_in)));
    end
endmodule : cfig_accept
`default_nettype wire

// >>> design/cfig_flags.sv
// Behaviour
// - Bank flag picks register bank zero/one
// - Overflow flag follows each arithmetic result
// - Enable flag zero blocks maskable interrupts
// - Accepting an interrupt clears enable flag
// - Stack flag picks interrupt or user pointer
// - Hardware interrupt or low trap clears stack flag
// - Priority level is three bits, 0..7
// - Interrupt needs priority above current level; here a non-maskable request is taken at any level
// - Reserved bits read indeterminate; here zero
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`default_nettype none
module cfig_flags (
    input  wire logic        core_clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    input  wire logic        arith_done_in,
    input  wire logic        arith_ovf_in,
    input  wire logic        trap_in,
    input  wire logic [5:0]  trap_num_in,
    input  wire logic        irq_req_in,
    input  wire logic        irq_nmi_in,
    input  wire logic [2:0]  irq_level_in,
    output logic             irq_take_out,
    output logic             bank_sel_out,
    output logic             user_stack_sel_out,
    output logic             overflow_out,
    output logic             ien_out
);
    typedef struct packed {
        logic       wr_pend;
        logic [7:0] wr_addr;
        logic [7:0] rd_addr;
        logic       bank;
        logic       ovf;
        logic       ien;
        logic       ssel;
        logic [2:0] lvl;
        logic       take;
        logic [31:0] rdata;
    } cfig_state_t;

    cfig_state_t s_q;
    cfig_state_t s_d;
    logic        rst_s1_q;
    logic        rst_s2_q;
    logic        take_w;
    logic        addr_ok;
    logic        flag_wr;

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    cfig_accept u_accept (
        .irq_req_in             (irq_req_in),
        .irq_nmi_in             (irq_nmi_in),
        .irq_level_in           (irq_level_in),
        .ien_in                 (s_q.ien),
        .core_priority_level_in (s_q.lvl),
        .take_out               (take_w)
    );

    assign addr_ok = hsel_in && hready_in && (htrans_in == cfig_pkg::HTRANS_NONSEQ);
    assign flag_wr = s_q.wr_pend && (s_q.wr_addr == cfig_pkg::FLAG_OFS);

    always_comb
    begin
        s_d = s_q;
        s_d.take = take_w;
        s_d.wr_pend = addr_ok && hwrite_in && (hsize_in == cfig_pkg::HSIZE_WORD);
        s_d.wr_addr = haddr_in[7:0];
        // Software write of the flag word; reserved bits dropped
        if (flag_wr)
        begin
            s_d.bank = hwdata_in[cfig_pkg::BANK_BIT];
            s_d.ovf  = hwdata_in[cfig_pkg::OVF_BIT];
            s_d.ien  = hwdata_in[cfig_pkg::IEN_BIT];
            s_d.ssel = hwdata_in[cfig_pkg::SSEL_BIT];
            s_d.lvl  = hwdata_in[cfig_pkg::LVL_LSB +: cfig_pkg::LVL_W];
        end
        // Hardware events override a coincident write
        if (arith_done_in)
            s_d.ovf = arith_ovf_in;
        if (trap_in && (trap_num_in <= cfig_pkg::TRAP_MAX))
            s_d.ssel = 1'b0;
        if (take_w)
        begin
            s_d.ien  = 1'b0;
            s_d.ssel = 1'b0;
        end
        s_d.rdata = 32'h0000_0000;
        if (addr_ok && !hwrite_in)
        begin
            case (haddr_in[7:0])
                cfig_pkg::FLAG_OFS:
                    s_d.rdata = {25'h0, s_d.lvl, s_d.ssel, s_d.ien, s_d.ovf, s_d.bank};
                cfig_pkg::STATUS_OFS:
                    s_d.rdata = {31'h0, take_w};
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign hrdata_out         = s_q.rdata;
    assign hreadyout_out      = rst_s2_q;
    assign hresp_out          = 1'b0;
    assign irq_take_out       = s_q.take;
    assign bank_sel_out       = s_q.bank;
    assign user_stack_sel_out = s_q.ssel;
    assign overflow_out       = s_q.ovf;
    assign ien_out            = s_q.ien;

    // Hardware events on the flags
    a_take_clears_ien: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        take_w |=> !s_q.ien)
        else $error("enable not cleared");
    a_take_clears_ssel: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        take_w |=> !s_q.ssel)
        else $error("stack flag not cleared");
    a_trap_clears_ssel: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (trap_in && trap_num_in < 6'h20) |=> !s_q.ssel)
        else $error("trap kept stack");
    a_high_trap_keeps: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (trap_in && (trap_num_in > cfig_pkg::TRAP_MAX) && !take_w && !flag_wr) |=> $stable(user_stack_sel_out))
        else $error("high trap moved stack flag");
    a_ovf_tracks: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        arith_done_in |=> (s_q.ovf == $past(arith_ovf_in)))
        else $error("overflow wrong");
    a_ovf_hold: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (!arith_done_in && !flag_wr) |=> $stable(overflow_out))
        else $error("overflow moved");

    // Acceptance of requests
    a_mask_blocks: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (!irq_nmi_in && !s_q.ien) |-> !take_w)
        else $error("masked taken");
    a_no_request: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        !irq_req_in |=> !irq_take_out)
        else $error("take without request");
    a_level_gate: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (take_w && !irq_nmi_in) |-> (irq_level_in > s_q.lvl))
        else $error("level low");
    a_accept_taken: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (irq_req_in && !irq_nmi_in && s_q.ien && (irq_level_in > s_q.lvl)) |=> irq_take_out)
        else $error("eligible request refused");
    a_nmi_bypass: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (irq_req_in && irq_nmi_in) |=> irq_take_out)
        else $error("nmi lost");

    // Flag word writes, holds and reads
    a_bank_out: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        flag_wr |=> (bank_sel_out == $past(hwdata_in[cfig_pkg::BANK_BIT])))
        else $error("bank wrong");
    a_bank_hold: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        !flag_wr |=> $stable(bank_sel_out))
        else $error("bank moved");
    a_ien_hold: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (!flag_wr && !take_w) |=> $stable(ien_out))
        else $error("enable moved");
    a_ssel_hold: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (!flag_wr && !take_w && !trap_in) |=> $stable(user_stack_sel_out))
        else $error("stack flag moved");
    a_ssel_write: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (flag_wr && !take_w && !trap_in) |=> (user_stack_sel_out == $past(hwdata_in[cfig_pkg::SSEL_BIT])))
        else $error("stack flag write lost");
    a_lvl_write: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        flag_wr |=> (s_q.lvl == $past(hwdata_in[cfig_pkg::LVL_LSB +: cfig_pkg::LVL_W])))
        else $error("level write lost");
    a_lvl_hold: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        !flag_wr |=> $stable(s_q.lvl))
        else $error("level moved");
    a_flag_read: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        (addr_ok && !hwrite_in && (haddr_in[7:0] == cfig_pkg::FLAG_OFS))
            |=> (hrdata_out[6:0] == {s_q.lvl, s_q.ssel, s_q.ien, s_q.ovf, s_q.bank}))
        else $error("flag read wrong");
    a_rsvd_read: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        hrdata_out[31:7] == 25'h0)
        else $error("reserved bits not zero");
    a_read_idle: assert property (@(posedge core_clk_in) disable iff (!rst_s2_q)
        !(addr_ok && !hwrite_in) |=> (hrdata_out == 32'h0))
        else $error("read data not cleared");

    c_nmi: cover property (@(posedge core_clk_in) irq_req_in && irq_nmi_in);
    c_mask_take: cover property (@(posedge core_clk_in) take_w && !irq_nmi_in);
    c_trap: cover property (@(posedge core_clk_in) trap_in && trap_num_in < 6'h20);
    c_level_refused: cover property (@(posedge core_clk_in)
        irq_req_in && !irq_nmi_in && s_q.ien && (irq_level_in <= s_q.lvl));
    c_flag_write: cover property (@(posedge core_clk_in) flag_wr);
endmodule : cfig_flags
`default_nettype wire

// >>> testbench/cfig_src.sv
`default_nettype none
module cfig_src (
    input  wire logic       clk_in,
    input  wire logic       take_in,
    output logic            done_out,
    output logic            ovf_out,
    output logic            trap_out,
    output logic [5:0]      num_out,
    output logic            req_out,
    output logic            nmi_out,
    output logic [2:0]      lvl_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {done_out, ovf_out, trap_out, num_out, req_out, nmi_out, lvl_out} = '0;
    task automatic op(input logic ovf, input logic trp, input logic [5:0] num);
        @(posedge clk_in);
        done_out <= !trp;
        ovf_out  <= ovf;
        trap_out <= trp;
        num_out  <= num;
        @(posedge clk_in);
        done_out <= 1'b0;
        trap_out <= 1'b0;
        ovf_out  <= !ovf;
        num_out  <= ~num;
    endtask : op
    task automatic irq(input logic nmi, input logic [2:0] lvl, output logic taken);
        @(posedge clk_in);
        req_out <= 1'b1;
        nmi_out <= nmi;
        lvl_out <= lvl;
        @(posedge clk_in);
        req_out <= 1'b0;
        nmi_out <= 1'b0;
        lvl_out <= ~lvl;
        @(posedge clk_in);
        taken = take_in;
    endtask : irq
endmodule : cfig_src
`default_nettype wire

// >>> testbench/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, hwrite = 0, hready, hresp, take, bank, user_stack_pointer, ovf, ien, tk;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic        done, aovf, trp, req, nmi;
    logic [5:0]  num;
    logic [2:0]  lvl;
    int          mismatches = 0, checks_done = 0;
    cfig_flags u_cfig_flags (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .arith_done_in(done), .arith_ovf_in(aovf), .trap_in(trp), .trap_num_in(num), .irq_req_in(req),
        .irq_nmi_in(nmi), .irq_level_in(lvl), .irq_take_out(take), .bank_sel_out(bank),
        .user_stack_sel_out(user_stack_pointer), .overflow_out(ovf), .ien_out(ien));
    cfig_src u_src (.clk_in(clk), .take_in(take), .done_out(done), .ovf_out(aovf), .trap_out(trp),
        .num_out(num), .req_out(req), .nmi_out(nmi), .lvl_out(lvl));
    initial forever #4 clk = ~clk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        htrans <= cfig_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        hsize  <= cfig_pkg::HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata & 32'h7f;
        hwdata <= ~wd;
    endtask : bus
    task automatic t_regs();
        bus(0, 8'h00, 0);
        chk("flag reset", 0, rd);
        bus(1, 8'h00, 32'h5b);
        bus(0, 8'h00, 0);
        chk("flag word", 32'h5b, rd);
        chk("outs", 4'h7, {ien, user_stack_pointer, ovf, bank});
        bus(1, 8'h00, 32'h74);
        bus(0, 8'h00, 0);
        chk("flag word", 32'h74, rd);
        chk("outs", 4'h8, {ien, user_stack_pointer, ovf, bank});
        bus(0, 8'h0c, 0);
        chk("unmapped", 0, rd);
        bus(0, 8'h04, 0);
        chk("status", 0, rd);
        chk("resp", 0, hresp);
    endtask : t_regs
    task automatic t_ovt();
        logic [5:0] n [4] = '{6'h1f, 6'h20, 6'h00, 6'h3f};
        for (int i = 0; i < 4; i++)
        begin
            u_src.op(i[0], 0, 0);
            @(posedge clk);
            chk("overflow", i[0], ovf);
            bus(1, 8'h00, 32'h08);
            u_src.op(0, 1, n[i]);
            @(posedge clk);
            chk("stack sel", n[i] > 6'h1f, user_stack_pointer);
        end
    endtask : t_ovt
    task automatic t_irq();
        logic [7:0] w [5] = '{8'h3d, 8'h3d, 8'h09, 8'h79, 8'h7d};
        logic [2:0] l [5] = '{3'h3, 3'h4, 3'h7, 3'h0, 3'h7};
        logic [4:0] nm = 5'b01000, ex = 5'b01010;
        for (int i = 0; i < 5; i++)
        begin
            bus(1, 8'h00, {24'h0, w[i]});
            u_src.irq(nm[i], l[i], tk);
            chk("accept", ex[i], tk);
            bus(0, 8'h00, 0);
            chk("flags after", ex[i] ? w[i] & 8'h73 : w[i], rd);
        end
    endtask : t_irq
    task automatic stop_test();
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_ovt();
        t_irq();
        stop_test();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule : testbench
`default_nettype wire
